// [pkg/mitu_params.svh]
// constants for the machine interrupt and timer unit
`ifndef MITU_PARAMS_SVH
`define MITU_PARAMS_SVH

// interrupt bit positions within the pending and enable layout
`define MITU_BIT_USI 4'h0
`define MITU_BIT_SSI 4'h1
`define MITU_BIT_MSI 4'h3
`define MITU_BIT_UTI 4'h4
`define MITU_BIT_STI 4'h5
`define MITU_BIT_MTI 4'h7
`define MITU_BIT_UEI 4'h8
`define MITU_BIT_SEI 4'h9
`define MITU_BIT_MEI 4'hb

// width of the standard interrupt field
`define MITU_NBITS 12

// level groups of the standard field
`define MITU_MASK_M 12'h888
`define MITU_MASK_S 12'h222
`define MITU_MASK_U 12'h111

// bits writable through the machine pending view, and through lower views
`define MITU_M_PEND_WMASK 12'h333
`define MITU_SIP_WMASK 12'h003
`define MITU_UIP_WMASK 12'h001

// memory-mapped word indices
`define MITU_MM_SOFT 3'h0
`define MITU_MM_TIME_LO 3'h1
`define MITU_MM_TIME_HI 3'h2
`define MITU_MM_CMP_LO 3'h3
`define MITU_MM_CMP_HI 3'h4

// reset values
`define MITU_TIME_RESET 64'h0000_0000_0000_0000
`define MITU_CMP_RESET 64'hffff_ffff_ffff_ffff
`define MITU_ZERO32 32'h0000_0000
`define MITU_ZERO12 12'h000

`endif

// [pkg/mitu_pkg.sv]
// types for the machine interrupt and timer unit
package mitu_pkg;

	typedef enum logic [1:0] {
		MITU_PRIV_U = 2'b00,
		MITU_PRIV_S = 2'b01,
		MITU_PRIV_M = 2'b11
	} mitu_priv_e;

	typedef enum logic [2:0] {
		MITU_SEL_M_PEND = 3'b000,
		MITU_SEL_M_EN = 3'b001,
		MITU_SEL_DELEG = 3'b010,
		MITU_SEL_SIP = 3'b011,
		MITU_SEL_SIE = 3'b100,
		MITU_SEL_UIP = 3'b101,
		MITU_SEL_UIE = 3'b110
	} mitu_csr_sel_e;

	typedef enum logic [1:0] {
		MITU_OP_READ = 2'b00,
		MITU_OP_SWAP = 2'b01,
		MITU_OP_SET = 2'b10,
		MITU_OP_CLEAR = 2'b11
	} mitu_csr_op_e;

	typedef struct packed {
		logic valid;
		mitu_csr_sel_e sel;
		mitu_csr_op_e op;
		logic [31:0] wdata;
	} mitu_csr_req_s;

	typedef struct packed {
		logic ack;
		logic denied;
		logic [31:0] rdata;
	} mitu_csr_rsp_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] word;
		logic [31:0] wdata;
	} mitu_mm_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} mitu_mm_rsp_s;

	typedef struct packed {
		mitu_priv_e priv;
		logic m_ie;
		logic s_ie;
		logic u_ie;
	} mitu_hart_s;

	typedef struct packed {
		logic valid;
		mitu_priv_e mode;
		logic [3:0] num;
	} mitu_irq_s;

endpackage

// [core/mitu_core.sv]
// machine interrupt and timer unit: pending/enable/delegation, priority, wall clock timer
//
// Contract
// - machine pending view writes only lower software, timer, external bits.
// - delegated bits show in lower views; undelegated view bits read zero.
// - enable layout: external 11/9/8, timer 7/5/4, software 3/1/0; 10,6,2 reserved.
// - machine timer pending read-only; cleared by a compare register write or a counter write below compare.
// - supervisor and user timer pending bits writable by machine software.
// - lower software pending bits accessible at their level or higher.
// - machine software pending set and cleared only by memory-mapped register.
// - machine external pending is read-only and follows the controller level.
// - supervisor/user external request is software bit OR controller signal.
// - reads return ORed external bit; set/clear use software bit only.
// - non-maskable interrupt never appears in the pending register.
// - bits of unsupported levels hardwired to zero.
// - bits 16 up unused here; 15-12, 10, 6, 2 stay reserved zero.
// - take interrupt only when pending, enabled and globally enabled.
// - undelegated: enabled below machine, or machine with machine enable.
// - delegated: enabled at delegated mode with its enable, or below it.
// - highest destination privilege mode is served first.
// - within a mode order is MEI MSI MTI SEI SSI STI UEI USI UTI.
// - 64-bit memory-mapped read-write wall clock counter at constant rate.
// - timer pending while counter not below 64-bit compare value.
// - counter and compare writes reach timer pending after some cycles.
// - each compare write changes one 32-bit half only.
// - delegation register uses the pending register bit layout.
`timescale 1ns/10ps
`include "mitu_params.svh"

module mitu_core #(
	parameter bit SUPPORT_S = 1'b1,
	parameter bit SUPPORT_U_IRQ = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire mitu_pkg::mitu_csr_req_s csr_req_i,
	output mitu_pkg::mitu_csr_rsp_s csr_rsp_o,
	input wire mitu_pkg::mitu_mm_req_s mm_req_i,
	output mitu_pkg::mitu_mm_rsp_s mm_rsp_o,
	input wire mitu_pkg::mitu_hart_s hart_i,
	input wire logic ext_m_irq_i,
	input wire logic ext_s_irq_i,
	input wire logic ext_u_irq_i,
	input wire logic rtc_tick_i,
	output mitu_pkg::mitu_irq_s irq_o
);
	import mitu_pkg::*;

	localparam int NB = `MITU_NBITS;
	localparam int NPRIO = 9;
	localparam logic [3:0] PRIO [NPRIO] = '{
		`MITU_BIT_MEI, `MITU_BIT_MSI, `MITU_BIT_MTI,
		`MITU_BIT_SEI, `MITU_BIT_SSI, `MITU_BIT_STI,
		`MITU_BIT_UEI, `MITU_BIT_USI, `MITU_BIT_UTI
	};
	localparam logic [NB-1:0] ZERO_NB = `MITU_ZERO12;
	// implemented bits, unsupported levels stay zero
	localparam logic [NB-1:0] IMPL = `MITU_MASK_M |
		(SUPPORT_S ? `MITU_MASK_S : ZERO_NB) |
		(SUPPORT_U_IRQ ? `MITU_MASK_U : ZERO_NB);
	localparam logic [NB-1:0] DELEG_OK = IMPL & ~`MITU_MASK_M;
	// delegated interrupts land in supervisor if present, else user
	localparam mitu_priv_e DLG_MODE = SUPPORT_S ? MITU_PRIV_S : MITU_PRIV_U;

	// field must hold every standard bit and still fit the 32-bit data word
	if ((NB <= `MITU_BIT_MEI) || (NB > 32)) begin : g_bad_width
		$error("mitu_core: standard field width cannot serve the interrupt layout");
	end

	// delegation needs a lower level to land in
	if (!SUPPORT_S && !SUPPORT_U_IRQ && (DELEG_OK != ZERO_NB)) begin : g_bad_cfg
		$error("mitu_core: delegation mask inconsistent with configuration");
	end

	// input synchronisers
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic tick_prev;
	logic machine_ext_pending;
	logic super_ext_pending_ext;
	logic user_ext_pending_ext;
	logic tick_pulse;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			tick_prev <= 1'b0;
		end else begin
			sync_a <= {rtc_tick_i, ext_u_irq_i, ext_s_irq_i, ext_m_irq_i};
			sync_b <= sync_a;
			tick_prev <= sync_b[3];
		end
	end

	assign machine_ext_pending = sync_b[0];
	assign super_ext_pending_ext = sync_b[1];
	assign user_ext_pending_ext = sync_b[2];
	assign tick_pulse = sync_b[3] & ~tick_prev;

	// state
	logic [NB-1:0] sw_pend;
	logic [NB-1:0] enable;
	logic [NB-1:0] deleg;
	logic machine_soft_pending;
	logic machine_timer_pending;
	logic [63:0] wall_clock_counter;
	logic [63:0] wall_clock_compare;

	// hardware-driven pending bits
	logic [NB-1:0] hw_vec;
	always_comb begin
		hw_vec = ZERO_NB;
		hw_vec[`MITU_BIT_MEI] = machine_ext_pending;
		hw_vec[`MITU_BIT_MSI] = machine_soft_pending;
		hw_vec[`MITU_BIT_MTI] = machine_timer_pending;
		hw_vec[`MITU_BIT_SEI] = super_ext_pending_ext;
		hw_vec[`MITU_BIT_UEI] = user_ext_pending_ext;
	end

	// no nmi term enters the pending vector
	logic [NB-1:0] pend_vec;
	assign pend_vec = (sw_pend | hw_vec) & IMPL;

	// csr view decode
	logic csr_is_pend;
	logic csr_is_en;
	logic csr_is_deleg;
	logic csr_allowed;
	logic [NB-1:0] view_mask;
	logic [NB-1:0] pend_wmask;

	assign csr_is_pend = (csr_req_i.sel == MITU_SEL_M_PEND) || (csr_req_i.sel == MITU_SEL_SIP) ||
		(csr_req_i.sel == MITU_SEL_UIP);
	assign csr_is_en = (csr_req_i.sel == MITU_SEL_M_EN) || (csr_req_i.sel == MITU_SEL_SIE) ||
		(csr_req_i.sel == MITU_SEL_UIE);
	assign csr_is_deleg = (csr_req_i.sel == MITU_SEL_DELEG);

	always_comb begin
		csr_allowed = 1'b0;
		view_mask = ZERO_NB;
		pend_wmask = ZERO_NB;
		case (csr_req_i.sel)
			MITU_SEL_M_PEND, MITU_SEL_M_EN, MITU_SEL_DELEG: begin
				csr_allowed = (hart_i.priv == MITU_PRIV_M);
				view_mask = IMPL;
				pend_wmask = `MITU_M_PEND_WMASK & IMPL;
			end
			MITU_SEL_SIP, MITU_SEL_SIE: begin
				csr_allowed = SUPPORT_S && (hart_i.priv != MITU_PRIV_U);
				view_mask = deleg & IMPL;
				pend_wmask = `MITU_SIP_WMASK & deleg & IMPL;
			end
			MITU_SEL_UIP, MITU_SEL_UIE: begin
				csr_allowed = SUPPORT_U_IRQ;
				view_mask = deleg & `MITU_MASK_U & IMPL;
				pend_wmask = `MITU_UIP_WMASK & deleg & IMPL;
			end
			default: begin
				csr_allowed = 1'b0;
				view_mask = ZERO_NB;
				pend_wmask = ZERO_NB;
			end
		endcase
	end

	// read value and read-modify-write base
	logic [NB-1:0] csr_read_val;
	logic [NB-1:0] rmw_old;
	logic [NB-1:0] rmw_new;
	logic [NB-1:0] csr_wdata_nb;
	logic csr_do;
	logic csr_write;

	assign csr_read_val = csr_is_deleg ? deleg :
		csr_is_en ? (enable & view_mask) : (pend_vec & view_mask);
	// pending rmw uses only software bits, never the controller level
	assign rmw_old = csr_is_deleg ? deleg :
		csr_is_en ? (enable & view_mask) : (sw_pend & view_mask);
	assign csr_wdata_nb = csr_req_i.wdata[NB-1:0];
	assign rmw_new = (csr_req_i.op == MITU_OP_SWAP) ? csr_wdata_nb :
		(csr_req_i.op == MITU_OP_SET) ? (rmw_old | csr_wdata_nb) :
		(rmw_old & ~csr_wdata_nb);
	assign csr_do = csr_req_i.valid && csr_allowed;
	assign csr_write = csr_do && (csr_req_i.op != MITU_OP_READ);

	logic [NB-1:0] next_sw_pend;
	logic [NB-1:0] next_enable;
	logic [NB-1:0] next_deleg;
	logic [NB-1:0] en_wmask;

	assign en_wmask = csr_is_en ? view_mask : ZERO_NB;
	assign next_sw_pend = (csr_write && csr_is_pend) ?
		((sw_pend & ~pend_wmask) | (rmw_new & pend_wmask)) : sw_pend;
	assign next_enable = csr_write ?
		((enable & ~en_wmask) | (rmw_new & en_wmask)) : enable;
	assign next_deleg = (csr_write && csr_is_deleg) ? (rmw_new & DELEG_OK) : deleg;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sw_pend <= ZERO_NB;
			enable <= ZERO_NB;
			deleg <= ZERO_NB;
		end else begin
			sw_pend <= next_sw_pend;
			enable <= next_enable;
			deleg <= next_deleg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			csr_rsp_o <= '0;
		end else begin
			csr_rsp_o.ack <= csr_req_i.valid;
			csr_rsp_o.denied <= csr_req_i.valid && !csr_allowed;
			csr_rsp_o.rdata <= csr_do ? {{(32-NB){1'b0}}, csr_read_val} : `MITU_ZERO32;
		end
	end

	// memory-mapped software interrupt and timer
	logic mm_wr;
	logic wr_soft;
	logic wr_time_lo;
	logic wr_time_hi;
	logic wr_cmp_lo;
	logic wr_cmp_hi;
	logic [63:0] time_inc;
	logic [63:0] next_counter;
	logic [63:0] next_compare;
	logic [31:0] mm_read_val;

	assign mm_wr = mm_req_i.valid && mm_req_i.write;
	assign wr_soft = mm_wr && (mm_req_i.word == `MITU_MM_SOFT);
	assign wr_time_lo = mm_wr && (mm_req_i.word == `MITU_MM_TIME_LO);
	assign wr_time_hi = mm_wr && (mm_req_i.word == `MITU_MM_TIME_HI);
	assign wr_cmp_lo = mm_wr && (mm_req_i.word == `MITU_MM_CMP_LO);
	assign wr_cmp_hi = mm_wr && (mm_req_i.word == `MITU_MM_CMP_HI);

	assign time_inc = tick_pulse ? (wall_clock_counter + 64'h0000_0000_0000_0001) :
		wall_clock_counter;
	// a write to either half wins over the tick for that half in the same cycle; the other half still takes the tick
	assign next_counter = wr_time_lo ? {time_inc[63:32], mm_req_i.wdata} :
		wr_time_hi ? {mm_req_i.wdata, time_inc[31:0]} : time_inc;
	assign next_compare = wr_cmp_lo ? {wall_clock_compare[63:32], mm_req_i.wdata} :
		wr_cmp_hi ? {mm_req_i.wdata, wall_clock_compare[31:0]} :
		wall_clock_compare;

	always_comb begin
		case (mm_req_i.word)
			`MITU_MM_SOFT: mm_read_val = {31'h0000_0000, machine_soft_pending};
			`MITU_MM_TIME_LO: mm_read_val = wall_clock_counter[31:0];
			`MITU_MM_TIME_HI: mm_read_val = wall_clock_counter[63:32];
			`MITU_MM_CMP_LO: mm_read_val = wall_clock_compare[31:0];
			`MITU_MM_CMP_HI: mm_read_val = wall_clock_compare[63:32];
			default: mm_read_val = `MITU_ZERO32;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			machine_soft_pending <= 1'b0;
			wall_clock_counter <= `MITU_TIME_RESET;
			wall_clock_compare <= `MITU_CMP_RESET;
			machine_timer_pending <= 1'b0;
		end else begin
			if (wr_soft) begin
				machine_soft_pending <= mm_req_i.wdata[0];
			end
			wall_clock_counter <= next_counter;
			wall_clock_compare <= next_compare;
			// compare of stored values: reflects writes one cycle late
			// a counter write below compare also drops the level
			machine_timer_pending <= (wall_clock_counter >= wall_clock_compare);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mm_rsp_o <= '0;
		end else begin
			mm_rsp_o.ack <= mm_req_i.valid;
			mm_rsp_o.rdata <= (mm_req_i.valid && !mm_req_i.write) ? mm_read_val : `MITU_ZERO32;
		end
	end

	// global enables per destination mode
	logic gie_m;
	logic gie_dlg;
	logic priv_below_dlg;

	assign gie_m = (hart_i.priv != MITU_PRIV_M) || hart_i.m_ie;
	assign priv_below_dlg = (DLG_MODE == MITU_PRIV_S) && (hart_i.priv == MITU_PRIV_U);
	assign gie_dlg = ((hart_i.priv == DLG_MODE) &&
		((DLG_MODE == MITU_PRIV_S) ? hart_i.s_ie : hart_i.u_ie)) ||
		priv_below_dlg;

	logic [NB-1:0] avail;
	logic [NB-1:0] take_m;
	logic [NB-1:0] take_d;

	assign avail = pend_vec & enable & IMPL;
	assign take_m = avail & ~deleg & {NB{gie_m}};
	assign take_d = avail & deleg & {NB{gie_dlg}};

	function automatic logic [4:0] pick_first(input logic [NB-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int k = NPRIO - 1; k >= 0; k--) begin
			if (v[PRIO[k]]) begin
				r = {1'b1, PRIO[k]};
			end
		end
		return r;
	endfunction

	logic [4:0] pick_m;
	logic [4:0] pick_d;
	mitu_irq_s next_irq;

	assign pick_m = pick_first(take_m);
	assign pick_d = pick_first(take_d);

	always_comb begin
		next_irq = '0;
		if (pick_m[4]) begin
			next_irq.valid = 1'b1;
			next_irq.mode = MITU_PRIV_M;
			next_irq.num = pick_m[3:0];
		end else if (pick_d[4]) begin
			next_irq.valid = 1'b1;
			next_irq.mode = DLG_MODE;
			next_irq.num = pick_d[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_o <= '0;
		end else begin
			irq_o <= next_irq;
		end
	end

endmodule // mitu_core

// [dv/mitu_chk_sva.sv]
// assertion checker for the interrupt and timer unit ports
`timescale 1ns/10ps
module mitu_chk (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire mitu_pkg::mitu_csr_req_s csr_req_i,
	input wire mitu_pkg::mitu_csr_rsp_s csr_rsp_o,
	input wire mitu_pkg::mitu_mm_req_s mm_req_i,
	input wire mitu_pkg::mitu_mm_rsp_s mm_rsp_o,
	input wire mitu_pkg::mitu_hart_s hart_i,
	input wire logic ext_m_irq_i,
	input wire mitu_pkg::mitu_irq_s irq_o
);
	import mitu_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_csr_answer_due: assert property (csr_req_i.valid |=> csr_rsp_o.ack || csr_rsp_o.denied)
		else $error("csr request not answered");
	chk_low_view_deny: assert property (csr_req_i.valid && csr_req_i.sel == MITU_SEL_SIP
		&& hart_i.priv == MITU_PRIV_U |=> csr_rsp_o.denied && csr_rsp_o.rdata == 32'h0000_0000)
		else $error("user access to supervisor view not denied");
	chk_upper_bits_zero: assert property (csr_rsp_o.ack |-> csr_rsp_o.rdata[31:12] == 20'h0_0000)
		else $error("reserved upper bits read nonzero");
	chk_irq_num_legal: assert property (irq_o.valid |-> irq_o.num inside
		{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hb})
		else $error("irq number is reserved");
	chk_machine_gate: assert property (irq_o.valid && irq_o.mode == MITU_PRIV_M |->
		$past(hart_i.priv) != MITU_PRIV_M || $past(hart_i.m_ie))
		else $error("machine irq while globally disabled");
	chk_deleg_gate: assert property (irq_o.valid && irq_o.mode == MITU_PRIV_S |->
		$past(hart_i.priv) == MITU_PRIV_U || ($past(hart_i.priv) == MITU_PRIV_S && $past(hart_i.s_ie)))
		else $error("delegated irq while globally disabled");
	chk_mm_ack_due: assert property (mm_req_i.valid |=> mm_rsp_o.ack)
		else $error("memory-mapped request not acknowledged");
	chk_ext_level_cause: assert property (irq_o.valid && irq_o.num == 4'hb |->
		$past(ext_m_irq_i, 3) || $past(ext_m_irq_i, 4))
		else $error("machine external irq without controller level");
endmodule // mitu_chk

// [dv/mitu_partner.sv]
// far-side model: external controller lines and wall clock timebase
`timescale 1ns/10ps
module mitu_partner (
	input wire logic clk_i,
	input wire logic tick_en_i,
	output logic [2:0] lines_o,
	output logic rtc_tick_o
);
	logic [1:0] div;
	initial begin
		lines_o = 3'h0;
		rtc_tick_o = 1'b0;
		div = 2'h0;
	end
	// level held until the controller itself drops it
	task automatic set_lines(input logic [2:0] v);
		lines_o = v;
	endtask
	// constant rate, one rising edge every eight clocks
	always @(posedge clk_i) begin
		div <= div + 2'h1;
		if (div == 2'h3) begin
			rtc_tick_o <= tick_en_i && !rtc_tick_o;
		end
	end
endmodule // mitu_partner

// [dv/machine_interrupt_and_timer_unit_test.sv]
// self-checking testbench for the interrupt and timer unit
`timescale 1ns/10ps
module machine_interrupt_and_timer_unit_test;
	import mitu_pkg::*;
	logic clk_i, rst_n_i, tick, tick_en, dn;
	logic [2:0] lines;
	logic [31:0] rd;
	mitu_csr_req_s creq;
	mitu_csr_rsp_s crsp;
	mitu_mm_req_s mreq;
	mitu_mm_rsp_s mrsp;
	mitu_hart_s hart;
	mitu_irq_s irq;
	int n_fail, checks;
	mitu_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .csr_req_i(creq), .csr_rsp_o(crsp),
		.mm_req_i(mreq), .mm_rsp_o(mrsp), .hart_i(hart), .ext_m_irq_i(lines[2]),
		.ext_s_irq_i(lines[1]), .ext_u_irq_i(lines[0]), .rtc_tick_i(tick), .irq_o(irq));
	mitu_partner part (.clk_i(clk_i), .tick_en_i(tick_en), .lines_o(lines), .rtc_tick_o(tick));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic csr(input mitu_csr_sel_e s, input mitu_csr_op_e o, input logic [31:0] w);
		@(posedge clk_i);
		#1 creq = '{1'b1, s, o, w};
		@(posedge clk_i);
		#1 rd = crsp.rdata;
		dn = crsp.denied;
		creq.valid = 1'b0;
	endtask
	task automatic mm(input logic [2:0] a, input logic wr, input logic [31:0] w);
		@(posedge clk_i);
		#1 mreq = '{1'b1, wr, a, w};
		@(posedge clk_i);
		#1 rd = mrsp.rdata;
		mreq.valid = 1'b0;
	endtask
	task automatic wait_irq(input logic [3:0] n, input mitu_priv_e m);
		int i;
		for (i = 0; i < 40 && !(irq.valid === 1'b1 && irq.num === n); i++) begin
			@(posedge clk_i);
			#1;
		end
		if (i == 40) begin
			n_fail++;
			print_verdict();
		end else begin
			chk("irq_mode", {30'h0, irq.mode}, {30'h0, m});
		end
	endtask
	task automatic quiet(input string nm);
		repeat (3) @(posedge clk_i);
		#1 chk(nm, {31'h0, irq.valid}, 32'h0000_0000);
	endtask
	task automatic t_views();
		mitu_csr_sel_e sl [3] = '{MITU_SEL_M_PEND, MITU_SEL_M_EN, MITU_SEL_DELEG};
		logic [31:0] ex [3] = '{32'h0000_0333, 32'h0000_0bbb, 32'h0000_0333};
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("pend_rst", rd, 32'h0000_0000);
		mm(3'h4, 1'b0, 32'h0);
		chk("cmp_rst", rd, 32'hffff_ffff);
		foreach (sl[i]) begin
			csr(sl[i], MITU_OP_SWAP, 32'hffff_ffff);
			csr(sl[i], MITU_OP_READ, 32'h0);
			chk("wr_mask", rd, ex[i]);
		end
		csr(MITU_SEL_DELEG, MITU_OP_SWAP, 32'h0000_0002);
		csr(MITU_SEL_SIP, MITU_OP_READ, 32'h0);
		chk("sip_view", rd, 32'h0000_0002);
		csr(MITU_SEL_SIE, MITU_OP_SWAP, 32'h0);
		csr(MITU_SEL_UIE, MITU_OP_SWAP, 32'hffff_ffff);
		csr(MITU_SEL_M_EN, MITU_OP_READ, 32'h0);
		chk("low_en_view", rd, 32'h0000_0bb9);
		csr(MITU_SEL_UIP, MITU_OP_READ, 32'h0);
		chk("uip_view", rd, 32'h0000_0000);
		csr(MITU_SEL_M_EN, MITU_OP_SWAP, 32'hffff_ffff);
		hart.priv = MITU_PRIV_U;
		csr(MITU_SEL_SIP, MITU_OP_SWAP, 32'h0);
		chk("sip_deny", {31'h0, dn}, 32'h0000_0001);
		hart.priv = MITU_PRIV_M;
		csr(MITU_SEL_M_PEND, MITU_OP_SWAP, 32'h0);
	endtask
	task automatic t_super_ext_pending();
		part.set_lines(3'b011);
		repeat (3) @(posedge clk_i);
		csr(MITU_SEL_M_PEND, MITU_OP_SET, 32'h0000_0001);
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("ext_or", rd, 32'h0000_0301);
		part.set_lines(3'b000);
		repeat (3) @(posedge clk_i);
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("rmw_sw_only", rd, 32'h0000_0001);
		csr(MITU_SEL_M_PEND, MITU_OP_CLEAR, 32'h0000_0001);
	endtask
	task automatic t_prio();
		logic [3:0] ord [9] = '{4'hb, 4'h3, 4'h7, 4'h9, 4'h1, 4'h5, 4'h8, 4'h0, 4'h4};
		csr(MITU_SEL_DELEG, MITU_OP_SWAP, 32'h0);
		csr(MITU_SEL_M_PEND, MITU_OP_SWAP, 32'h0000_0333);
		mm(3'h0, 1'b1, 32'h0000_0001);
		mm(3'h4, 1'b1, 32'h0);
		mm(3'h3, 1'b1, 32'h0);
		part.set_lines(3'b100);
		repeat (4) @(posedge clk_i);
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("all_pend", rd, 32'h0000_0bbb);
		foreach (ord[i]) begin
			wait_irq(ord[i], MITU_PRIV_M);
			case (ord[i])
				4'hb: part.set_lines(3'b000);
				4'h3: mm(3'h0, 1'b1, 32'h0);
				4'h7: mm(3'h3, 1'b1, 32'hffff_ffff);
				default: csr(MITU_SEL_M_PEND, MITU_OP_CLEAR, 32'h1 << ord[i]);
			endcase
		end
		quiet("all_clear");
	endtask
	task automatic t_gate();
		hart.m_ie = 1'b0;
		csr(MITU_SEL_M_PEND, MITU_OP_SWAP, 32'h0000_0002);
		quiet("m_masked");
		hart.priv = MITU_PRIV_S;
		wait_irq(4'h1, MITU_PRIV_M);
		hart = '{MITU_PRIV_M, 1'b1, 1'b1, 1'b0};
		csr(MITU_SEL_DELEG, MITU_OP_SWAP, 32'h0000_0002);
		quiet("deleg_m");
		hart = '{MITU_PRIV_S, 1'b1, 1'b0, 1'b0};
		quiet("deleg_s_off");
		hart.priv = MITU_PRIV_U;
		wait_irq(4'h1, MITU_PRIV_S);
		hart = '{MITU_PRIV_M, 1'b1, 1'b0, 1'b0};
		csr(MITU_SEL_M_PEND, MITU_OP_CLEAR, 32'h0000_0002);
		csr(MITU_SEL_DELEG, MITU_OP_SWAP, 32'h0);
	endtask
	task automatic t_timer();
		logic [31:0] held;
		mm(3'h1, 1'b1, 32'h0);
		mm(3'h2, 1'b1, 32'h0);
		repeat (80) @(posedge clk_i);
		mm(3'h1, 1'b0, 32'h0);
		chk("rtc_rate", {31'h0, rd >= 32'h9 && rd <= 32'hc}, 32'h0000_0001);
		tick_en = 1'b0;
		repeat (12) @(posedge clk_i);
		mm(3'h1, 1'b0, 32'h0);
		held = rd;
		repeat (24) @(posedge clk_i);
		mm(3'h1, 1'b0, 32'h0);
		chk("rtc_hold", rd, held);
		tick_en = 1'b1;
		mm(3'h3, 1'b1, 32'h0000_00c8);
		mm(3'h4, 1'b0, 32'h0);
		chk("cmp_half", rd, 32'h0000_0000);
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("mt_pend_low", rd, 32'h0000_0000);
		mm(3'h1, 1'b1, 32'h0000_00c7);
		repeat (12) @(posedge clk_i);
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("mt_pend_high", rd, 32'h0000_0080);
		mm(3'h4, 1'b1, 32'hffff_ffff);
		repeat (3) @(posedge clk_i);
		csr(MITU_SEL_M_PEND, MITU_OP_READ, 32'h0);
		chk("mt_pend_clr", rd, 32'h0000_0000);
		mm(3'h5, 1'b0, 32'h0);
		chk("unmapped", rd, 32'h0000_0000);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		rst_n_i = 1'b0;
		creq = '0;
		mreq = '0;
		hart = '{MITU_PRIV_M, 1'b1, 1'b0, 1'b0};
		tick_en = 1'b1;
		n_fail = 0;
		checks = 0;
		repeat (10) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		t_views();
		t_super_ext_pending();
		t_prio();
		t_gate();
		t_timer();
		print_verdict();
	end
endmodule // machine_interrupt_and_timer_unit_test
bind mitu_core mitu_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .csr_req_i(csr_req_i),
	.csr_rsp_o(csr_rsp_o), .mm_req_i(mm_req_i), .mm_rsp_o(mm_rsp_o), .hart_i(hart_i),
	.ext_m_irq_i(ext_m_irq_i), .irq_o(irq_o));
